/* File: logic/osq_top.sv */
// Manual command sequencer for the one-time-programmable memory macro
//
// Design decisions made here: the register addresses and register access over APB.
`include "osq_regs.svh"

module osq_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic cfg_read_done,
  output logic cfg_read_req,
  output logic mem_enable,
  output logic [3:0] mem_op,
  output logic mem_setup,
  output logic mem_pulse,
  output logic mem_hold,
  output logic mem_recover,
  output logic mem_mode_sel,
  output logic mem_aux_a,
  output logic mem_aux_b,
  output logic mem_all_bank,
  output logic busy
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations

  osq_pkg::osq_top_st_t r_reg; // Registered state of the whole block
  osq_pkg::osq_top_st_t r_next; // Next value of that state
  logic tick; // One-microsecond pulse from the divider
  logic acc_wr; // APB write access completes this cycle
  logic start_req; // Software asked for a manual command
  logic start_ok; // A manual command may begin
  logic [3:0] run_mask; // Stage mask of the running command
  logic run_assist; // Running command is the assist sequence

  ////////////////////////////////////////////////////////////////////////////
  // Functions

  // True for every offset that holds a register
  function automatic logic osq_mapped(input logic [7:0] a);
    logic hit;
    hit = 1'b0;
    if (a == `OSQ_OFF_PWR_REC) begin
      hit = 1'b1;
    end else if (a == `OSQ_OFF_ACCESS) begin
      hit = 1'b1;
    end else if (a == `OSQ_OFF_DIVIDER) begin
      hit = 1'b1;
    end else if (a == `OSQ_OFF_TIMING) begin
      hit = 1'b1;
    end else if (a == `OSQ_OFF_COMMAND) begin
      hit = 1'b1;
    end else if (a == `OSQ_OFF_CONTROL) begin
      hit = 1'b1;
    end else if (a == `OSQ_OFF_START) begin
      hit = 1'b1;
    end else if (a == `OSQ_OFF_STATUS) begin
      hit = 1'b1;
    end
    return hit;
  endfunction : osq_mapped

  // First enabled stage at or after position pos (0 setup .. 3 recovery)
  function automatic osq_pkg::osq_state_t osq_next_stage(
    input logic [3:0] mask,
    input logic assist,
    input int pos
  );
    osq_pkg::osq_state_t s;
    s = osq_pkg::st_idle;
    for (int i = 3; i >= 0; i--) begin
      // Mask bit 3 is setup, bit 0 is recovery; walk backwards so lowest wins
      if (i >= pos && mask[3-i] && !(assist && i == 2)) begin
        case (i)
          0: s = osq_pkg::st_setup;
          1: s = osq_pkg::st_pulse;
          2: s = osq_pkg::st_hold;
          default: s = osq_pkg::st_recov;
        endcase
      end
    end
    return s;
  endfunction : osq_next_stage

  // Cycle count loaded when a stage is entered; stage lasts this plus one
  function automatic logic [17:0] osq_stage_len(
    input logic [31:0] t,
    input osq_pkg::osq_state_t s
  );
    logic [17:0] len;
    len = 18'h00000;
    case (s)
      osq_pkg::st_setup: len = {16'h0000, t[`OSQ_SETUP_HI:`OSQ_SETUP_LO]};
      osq_pkg::st_pulse: len = t[`OSQ_PULSE_HI:`OSQ_PULSE_LO];
      osq_pkg::st_hold: len = {16'h0000, t[`OSQ_HOLD_HI:`OSQ_HOLD_LO]};
      osq_pkg::st_recov: len = {8'h00, t[`OSQ_RECOV_HI:`OSQ_RECOV_LO]};
      default: len = 18'h00000;
    endcase
    return len;
  endfunction : osq_stage_len

  // Position of a stage in the fixed order, used to find the following one
  function automatic int osq_stage_pos(input osq_pkg::osq_state_t s);
    int p;
    p = 4;
    case (s)
      osq_pkg::st_setup: p = 0;
      osq_pkg::st_pulse: p = 1;
      osq_pkg::st_hold: p = 2;
      osq_pkg::st_recov: p = 3;
      default: p = 4;
    endcase
    return p;
  endfunction : osq_stage_pos

  // Operation driven into the macro for a command code
  function automatic osq_pkg::osq_op_t osq_decode(input logic [3:0] code);
    osq_pkg::osq_op_t op;
    op = osq_pkg::op_none;
    case (code)
      4'h1: op = osq_pkg::op_reset;
      4'h4: op = osq_pkg::op_power_up;
      4'h5: op = osq_pkg::op_power_down;
      4'h6: op = osq_pkg::op_read;
      4'h7: op = osq_pkg::op_write;
      4'h8: op = osq_pkg::op_program;
      4'h9: op = osq_pkg::op_compare;
      4'hA: op = osq_pkg::op_charge;
      4'hB: op = osq_pkg::op_aux_update;
      4'hE: op = osq_pkg::op_assist;
      // Wait and unassigned codes still sequence but leave the macro alone
      default: op = osq_pkg::op_none;
    endcase
    return op;
  endfunction : osq_decode

  ////////////////////////////////////////////////////////////////////////////
  // Microsecond tick generator

  osq_tick #(
    .DIV_W(8)
  ) u_tick (
    .pclk(pclk),
    .presetn(presetn),
    .microsecond_divider(r_reg.divider),
    .tick(tick)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Bus qualifiers

  // The slave never stretches the access phase
  assign pready = 1'b1;
  // Unmapped offsets answer with an error in the access phase
  assign pslverr = psel && penable && !osq_mapped(paddr);
  assign acc_wr = psel && penable && pwrite && osq_mapped(paddr);
  // Start register write with bit 0 set requests a command
  assign start_req = acc_wr && (paddr == `OSQ_OFF_START) && pwdata[0];
  // Locked until the key is present, until start-up finishes, and while busy
  assign start_ok = start_req && (r_reg.access == `OSQ_ACCESS_KEY)
    && (r_reg.boot == osq_pkg::boot_done)
    && (r_reg.st == osq_pkg::st_idle);
  assign run_mask = r_reg.run_cmd[`OSQ_MASK_HI:`OSQ_MASK_LO];
  assign run_assist = (r_reg.run_cmd[`OSQ_CODE_HI:`OSQ_CODE_LO] == 4'hE);

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic

  always_comb begin
    r_next = r_reg;

    // Read data is captured in the setup phase so prdata comes from a flop
    if (psel && !penable && !pwrite) begin
      r_next.rdata = 32'h0000_0000;
      if (paddr == `OSQ_OFF_PWR_REC) begin
        r_next.rdata = {23'h000000, r_reg.pwr_rec};
      end else if (paddr == `OSQ_OFF_ACCESS) begin
        r_next.rdata = {24'h000000, r_reg.access};
      end else if (paddr == `OSQ_OFF_DIVIDER) begin
        r_next.rdata = {24'h000000, r_reg.divider};
      end else if (paddr == `OSQ_OFF_TIMING) begin
        r_next.rdata = r_reg.timing;
      end else if (paddr == `OSQ_OFF_COMMAND) begin
        r_next.rdata = {24'h000000, r_reg.command};
      end else if (paddr == `OSQ_OFF_CONTROL) begin
        // Low three control bits are reserved and read as zero
        r_next.rdata = {24'h000000, r_reg.control[7:3], 3'h0};
      end else if (paddr == `OSQ_OFF_START) begin
        r_next.rdata = {31'h00000000, r_reg.st != osq_pkg::st_idle};
      end else if (paddr == `OSQ_OFF_STATUS) begin
        r_next.rdata = {26'h0000000, r_reg.boot, r_reg.st, r_reg.st != osq_pkg::st_idle};
      end
    end

    // Register writes land on the completing access edge
    if (acc_wr) begin
      if (paddr == `OSQ_OFF_PWR_REC) begin
        r_next.pwr_rec = pwdata[8:0];
      end else if (paddr == `OSQ_OFF_ACCESS) begin
        r_next.access = pwdata[7:0];
      end else if (paddr == `OSQ_OFF_DIVIDER) begin
        r_next.divider = pwdata[7:0];
      end else if (paddr == `OSQ_OFF_TIMING) begin
        r_next.timing = pwdata;
      end else if (paddr == `OSQ_OFF_COMMAND) begin
        r_next.command = pwdata[7:0];
      end else if (paddr == `OSQ_OFF_CONTROL) begin
        r_next.control = {pwdata[7:3], 3'h0};
      end
    end

    // Start-up: power the macro, wait for supply recovery, read, switch off
    case (r_reg.boot)
      osq_pkg::boot_power: begin
        // Supply recovery counts microsecond ticks, not raw cycles
        if (tick) begin
          if (r_reg.boot_cnt >= r_reg.pwr_rec) begin
            r_next.boot = osq_pkg::boot_read;
          end else begin
            r_next.boot_cnt = r_reg.boot_cnt + 9'h001;
          end
        end
      end
      osq_pkg::boot_read: begin
        // Macro stays enabled until the configuration read reports done
        if (cfg_read_done) begin
          r_next.boot = osq_pkg::boot_done;
        end
      end
      default: begin
        r_next.boot = osq_pkg::boot_done;
      end
    endcase

    // Stage engine
    case (r_reg.st)
      osq_pkg::st_idle: begin
        if (start_ok) begin
          // Command is latched so later writes cannot disturb a running one
          r_next.run_cmd = r_reg.command;
          r_next.st = osq_next_stage(r_reg.command[`OSQ_MASK_HI:`OSQ_MASK_LO],
            r_reg.command[`OSQ_CODE_HI:`OSQ_CODE_LO] == 4'hE, 0);
          r_next.cnt = osq_stage_len(r_reg.timing, r_next.st);
        end
      end
      default: begin
        if (r_reg.cnt == 18'h00000) begin
          // Move to the next enabled stage, or back to idle after the last
          r_next.st = osq_next_stage(run_mask, run_assist,
            osq_stage_pos(r_reg.st) + 1);
          r_next.cnt = osq_stage_len(r_reg.timing, r_next.st);
        end else begin
          r_next.cnt = r_reg.cnt - 18'h00001;
        end
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r_reg.pwr_rec <= `OSQ_RST_PWR_REC;
      r_reg.access <= `OSQ_RST_ACCESS;
      r_reg.divider <= `OSQ_RST_DIVIDER;
      r_reg.timing <= `OSQ_RST_TIMING;
      r_reg.command <= `OSQ_RST_COMMAND;
      r_reg.control <= `OSQ_RST_CONTROL;
      r_reg.run_cmd <= 8'h00;
      r_reg.st <= osq_pkg::st_idle;
      r_reg.cnt <= 18'h00000;
      r_reg.boot <= osq_pkg::boot_power;
      r_reg.boot_cnt <= 9'h000;
      r_reg.rdata <= 32'h0000_0000;
    end else begin
      r_reg <= r_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign prdata = r_reg.rdata;
  assign busy = (r_reg.st != osq_pkg::st_idle);
  assign cfg_read_req = (r_reg.boot == osq_pkg::boot_read);

  // Start-up owns the enable until done, then the control bit does
  // Software is expected to set that bit before any manual command
  assign mem_enable = (r_reg.boot != osq_pkg::boot_done)
    || r_reg.control[`OSQ_CTL_ENABLE];

  // Operation: manual command while busy, a read during start-up, else none
  always_comb begin
    if (busy) begin
      mem_op = osq_decode(r_reg.run_cmd[`OSQ_CODE_HI:`OSQ_CODE_LO]);
    end else if (r_reg.boot == osq_pkg::boot_read) begin
      mem_op = osq_pkg::op_read;
    end else begin
      mem_op = osq_pkg::op_none;
    end
  end

  // Stage strobes, one level per stage
  assign mem_setup = (r_reg.st == osq_pkg::st_setup);
  assign mem_pulse = (r_reg.st == osq_pkg::st_pulse);
  assign mem_hold = (r_reg.st == osq_pkg::st_hold);
  assign mem_recover = (r_reg.st == osq_pkg::st_recov);

  // Selects follow control bits only while a manual command runs
  assign mem_aux_b = busy && r_reg.control[`OSQ_CTL_AUX_B];
  assign mem_aux_a = busy && r_reg.control[`OSQ_CTL_AUX_A];
  assign mem_mode_sel = busy && r_reg.control[`OSQ_CTL_MODE];
  // Single-bank macro; the bit is passed through as software left it
  assign mem_all_bank = r_reg.control[`OSQ_CTL_ALL_BANK];

endmodule : osq_top

/* File: logic/osq_regs.svh */
// Register offsets, field positions, reset values and keys of the sequencer
`ifndef OSQ_REGS_SVH
`define OSQ_REGS_SVH
// Byte offsets on the APB side, one aligned word each
`define OSQ_OFF_PWR_REC 8'h00
`define OSQ_OFF_ACCESS 8'h04
`define OSQ_OFF_DIVIDER 8'h08
`define OSQ_OFF_TIMING 8'h0C
`define OSQ_OFF_COMMAND 8'h10
`define OSQ_OFF_CONTROL 8'h14
`define OSQ_OFF_START 8'h18
`define OSQ_OFF_STATUS 8'h1C
// Reset values
`define OSQ_RST_PWR_REC 9'h12C
`define OSQ_RST_ACCESS 8'h00
`define OSQ_RST_DIVIDER 8'h77
`define OSQ_RST_TIMING 32'h0001_8070
`define OSQ_RST_COMMAND 8'h00
`define OSQ_RST_CONTROL 8'h08
// Key that unlocks manual triggering
`define OSQ_ACCESS_KEY 8'h97
// Timing field positions
`define OSQ_PULSE_HI 31
`define OSQ_PULSE_LO 14
`define OSQ_RECOV_HI 13
`define OSQ_RECOV_LO 4
`define OSQ_HOLD_HI 3
`define OSQ_HOLD_LO 2
`define OSQ_SETUP_HI 1
`define OSQ_SETUP_LO 0
// Command field positions
`define OSQ_MASK_HI 7
`define OSQ_MASK_LO 4
`define OSQ_CODE_HI 3
`define OSQ_CODE_LO 0
// Control bit positions
`define OSQ_CTL_ENABLE 7
`define OSQ_CTL_AUX_B 6
`define OSQ_CTL_AUX_A 5
`define OSQ_CTL_MODE 4
`define OSQ_CTL_ALL_BANK 3
`endif

/* File: logic/osq_pkg.sv */
// Types shared by the sequencer modules
package osq_pkg;

  // Stage engine states, Gray coded along setup, pulse, hold, recovery
  typedef enum logic [2:0] {
    st_idle = 3'h0,
    st_setup = 3'h1,
    st_pulse = 3'h3,
    st_hold = 3'h2,
    st_recov = 3'h6
  } osq_state_t;

  // Start-up sequence states
  typedef enum logic [1:0] {
    boot_power = 2'h0,
    boot_read = 2'h1,
    boot_done = 2'h3
  } osq_boot_t;

  // Operation codes presented to the memory macro
  typedef enum logic [3:0] {
    op_none = 4'h0,
    op_reset = 4'h1,
    op_power_up = 4'h4,
    op_power_down = 4'h5,
    op_read = 4'h6,
    op_write = 4'h7,
    op_program = 4'h8,
    op_compare = 4'h9,
    op_charge = 4'hA,
    op_aux_update = 4'hB,
    op_wait = 4'hD,
    op_assist = 4'hE
  } osq_op_t;

  // State of the microsecond tick generator
  typedef struct packed {
    logic [7:0] cnt;
    logic tick;
  } osq_tick_st_t;

  // State of the sequencer top
  typedef struct packed {
    logic [8:0] pwr_rec;
    logic [7:0] access;
    logic [7:0] divider;
    logic [31:0] timing;
    logic [7:0] command;
    logic [7:0] control;
    logic [7:0] run_cmd;
    osq_state_t st;
    logic [17:0] cnt;
    osq_boot_t boot;
    logic [8:0] boot_cnt;
    logic [31:0] rdata;
  } osq_top_st_t;

endpackage : osq_pkg

/* File: logic/osq_tick.sv */
// Programmable divider producing a one-microsecond tick
module osq_tick #(
  parameter int DIV_W = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [DIV_W-1:0] microsecond_divider,
  output logic tick
);

  osq_pkg::osq_tick_st_t r_reg; // Registered state
  osq_pkg::osq_tick_st_t r_next; // Next state

  ////////////////////////////////////////////////////////////////////////////
  // Count down from the divider value; a tick each time zero is reached
  always_comb begin
    r_next = r_reg;
    r_next.tick = 1'b0;
    if (r_reg.cnt == '0) begin
      r_next.cnt = microsecond_divider;
      r_next.tick = 1'b1;
    end else begin
      r_next.cnt = r_reg.cnt - 8'h01;
    end
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign tick = r_reg.tick; // One-cycle pulse from a flop

endmodule : osq_tick

/* File: bench/osq_top_props.sv */
// Checker watching the ports of the sequencer top
module osq_top_props (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic cfg_read_req,
  input wire logic mem_enable,
  input wire logic [3:0] mem_op,
  input wire logic mem_setup,
  input wire logic mem_pulse,
  input wire logic mem_hold,
  input wire logic mem_recover,
  input wire logic mem_mode_sel,
  input wire logic mem_aux_a,
  input wire logic mem_aux_b,
  input wire logic busy
);
  timeunit 1ns;
  timeprecision 1ps;
  // One clock domain, so one default clocking and one reset
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  ////////////////////////////////////////////////////////////////////////
  stage_onehot_a: assert property ($onehot0({mem_setup, mem_pulse, mem_hold, mem_recover}))
    else $error("two stages active at once");
  busy_stage_a: assert property (busy == (mem_setup | mem_pulse | mem_hold | mem_recover))
    else $error("busy does not match active stage");
  recov_last_a: assert property (mem_recover ##1 !mem_recover |-> !busy)
    else $error("stage after recovery");
  setup_first_a: assert property ($rose(mem_setup) |-> $past(busy) == 1'b0)
    else $error("setup stage not first");
  hold_order_a: assert property (mem_hold ##1 busy |-> mem_hold || mem_recover)
    else $error("hold not followed by recovery");
  wait_op_a: assert property (mem_op != 4'hD)
    else $error("wait code reached the macro");
  assist_hold_a: assert property (mem_op == 4'hE |-> !mem_hold)
    else $error("hold stage in assist command");
  // Only the start-up read may present an operation while no command runs
  idle_sel_a: assert property (
    !busy |-> mem_op == (cfg_read_req ? 4'h6 : 4'h0)
    && !mem_aux_a && !mem_aux_b && !mem_mode_sel)
    else $error("macro inputs active while idle");
  op_stable_a: assert property (busy && $past(busy) |-> $stable(mem_op))
    else $error("operation changed mid command");
  boot_enable_a: assert property (cfg_read_req |-> mem_enable)
    else $error("start-up read with macro disabled");
  // Main scenarios reached
  cmd_c: cover property ($rose(busy));
  hold_c: cover property (mem_hold && busy);
  boot_c: cover property ($rose(cfg_read_req));
endmodule : osq_top_props

bind osq_top osq_top_props u_osq_top_props (.pclk(pclk), .presetn(presetn),
  .cfg_read_req(cfg_read_req), .mem_enable(mem_enable), .mem_op(mem_op),
  .mem_setup(mem_setup), .mem_pulse(mem_pulse), .mem_hold(mem_hold),
  .mem_recover(mem_recover), .mem_mode_sel(mem_mode_sel), .mem_aux_a(mem_aux_a),
  .mem_aux_b(mem_aux_b), .busy(busy));

/* File: bench/osq_mem_model.sv */
// Behavioural memory macro answering the start-up read
module osq_mem_model #(
  parameter int LAT = 3 // Macro delivers configuration one cycle after this many request cycles
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic cfg_read_req,
  output logic cfg_read_done
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt; // Cycles since the read was requested
  ////////////////////////////////////////////////////////////////////////
  // Done after a fixed latency; a level until the request drops
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= 0;
      cfg_read_done <= 1'b0;
    end else if (cfg_read_req) begin
      cnt <= cnt + 1;
      cfg_read_done <= (cnt >= LAT);
    end else begin
      cnt <= 0;
      cfg_read_done <= 1'b0;
    end
  end
endmodule : osq_mem_model

/* File: bench/tb_top.sv */
// Self-checking bench for the manual command sequencer
`include "osq_regs.svh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, cfg_read_done, cfg_read_req, mem_enable;
  logic [3:0] mem_op;
  logic mem_setup, mem_pulse, mem_hold, mem_recover;
  logic mem_mode_sel, mem_aux_a, mem_aux_b, mem_all_bank, busy;
  int mismatches = 0;
  int comparisons = 0;
  int n_s, n_p, n_h, n_r, n_b; // Stage cycle counts of the last command
  logic [3:0] op_seen; // Operation shown during the command
  logic [2:0] sel_seen; // Aux B, aux A, mode as shown during the command
  logic [2:0] sel_exp; // Select bits expected from the control value
  logic [31:0] rd;
  logic err;
  int k;
  osq_top u_osq_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .cfg_read_done(cfg_read_done), .cfg_read_req(cfg_read_req),
    .mem_enable(mem_enable), .mem_op(mem_op), .mem_setup(mem_setup),
    .mem_pulse(mem_pulse), .mem_hold(mem_hold), .mem_recover(mem_recover),
    .mem_mode_sel(mem_mode_sel), .mem_aux_a(mem_aux_a), .mem_aux_b(mem_aux_b),
    .mem_all_bank(mem_all_bank), .busy(busy));
  osq_mem_model u_osq_mem_model (.pclk(pclk), .presetn(presetn),
    .cfg_read_req(cfg_read_req), .cfg_read_done(cfg_read_done));
  ////////////////////////////////////////////////////////////////////////
  // 20 MHz clock and a hang guard
  initial begin
    forever #25 pclk = ~pclk;
  end
  initial begin
    repeat (100000) @(posedge pclk);
    mismatches++;
    final_report();
  end
  // Tally stage cycles as the macro sees them
  always @(posedge pclk) begin
    if (busy === 1'b1) begin
      n_b++;
      n_s += int'(mem_setup);
      n_p += int'(mem_pulse);
      n_h += int'(mem_hold);
      n_r += int'(mem_recover);
      op_seen = mem_op;
      sel_seen = {mem_aux_b, mem_aux_a, mem_mode_sel};
    end
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic final_report();
    if (mismatches == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : final_report
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  // One APB transfer; request held until pready is sampled high
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      mismatches++;
      final_report();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer
  // A wait that used up its bound ends the run as a failure
  task automatic give_up(input logic hit);
    if (hit) begin
      mismatches++;
      final_report();
    end
  endtask : give_up
  // Runs one command, then compares stage lengths, operation and selects
  task automatic run(input logic [7:0] cmd, input logic [31:0] tm, input logic again,
                     input int es, input int ep, input int eh, input int er,
                     input logic [3:0] eop);
    int n;
    xfer(1'b1, `OSQ_OFF_TIMING, tm);
    xfer(1'b1, `OSQ_OFF_COMMAND, {24'h0, cmd});
    n_s = 0; n_p = 0; n_h = 0; n_r = 0; n_b = 0;
    op_seen = 4'h0;
    sel_seen = 3'h0;
    xfer(1'b1, `OSQ_OFF_START, 32'h1);
    if (again) xfer(1'b1, `OSQ_OFF_START, 32'h1);
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (busy !== 1'b0 && n < 300);
    give_up(n >= 300);
    check(32'(n_s), 32'(es));
    check(32'(n_p), 32'(ep));
    check(32'(n_h), 32'(eh));
    check(32'(n_r), 32'(er));
    check(32'(n_b), 32'(es + ep + eh + er));
    check({28'h0, op_seen}, {28'h0, eop});
    if (n_b > 0) check({29'h0, sel_seen}, {29'h0, sel_exp});
    check({28'h0, mem_op}, 32'h0);
  endtask : run
  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    xfer(1'b0, `OSQ_OFF_DIVIDER, 32'h0);
    check(rd, 32'h77);
    xfer(1'b0, `OSQ_OFF_PWR_REC, 32'h0);
    check(rd, 32'h12C);
    xfer(1'b0, `OSQ_OFF_TIMING, 32'h0);
    check(rd, 32'h0001_8070);
    xfer(1'b0, `OSQ_OFF_CONTROL, 32'h0);
    check(rd, 32'h08);
    xfer(1'b0, 8'h40, 32'h0);
    check({31'h0, err}, 32'h1);
    // Ten-cycle tick and four ticks of supply recovery
    xfer(1'b1, `OSQ_OFF_DIVIDER, 32'h09);
    xfer(1'b1, `OSQ_OFF_PWR_REC, 32'h03);
    k = 0;
    while (cfg_read_req !== 1'b1 && k < 2000) begin
      @(posedge pclk);
      k++;
    end
    give_up(k >= 2000);
    // The first tick still runs off the reset divider; later ones are ten cycles apart
    check(32'(k >= 121 && k <= 123), 32'h1);
    check({31'h0, mem_enable}, 32'h1);
    k = 0;
    do begin
      xfer(1'b0, `OSQ_OFF_STATUS, 32'h0);
      k++;
    end while (rd[5:4] !== 2'h3 && k < 50);
    give_up(k >= 50);
    check({31'h0, mem_enable}, 32'h0);
    check({31'h0, mem_all_bank}, 32'h1);
    sel_exp = 3'h7;
    xfer(1'b1, `OSQ_OFF_CONTROL, 32'hF8);
    run(8'hD6, 32'h0001_8070, 1'b0, 0, 0, 0, 0, 4'h0);
    xfer(1'b1, `OSQ_OFF_ACCESS, 32'h97);
    run(8'hD6, 32'h0001_8070, 1'b0, 1, 7, 0, 8, 4'h6);
    run(8'hF7, 32'h0000_000F, 1'b1, 4, 1, 4, 1, 4'h7);
    run(8'hFE, 32'h0001_807F, 1'b0, 4, 7, 0, 8, 4'hE);
    run(8'h4D, 32'h0000_0010, 1'b0, 0, 1, 0, 0, 4'h0);
    run(8'h06, 32'h0001_8070, 1'b0, 0, 0, 0, 0, 4'h0);
    sel_exp = 3'h2;
    xfer(1'b1, `OSQ_OFF_CONTROL, 32'hA8);
    for (int c = 0; c < 16; c++) begin
      run({4'h4, 4'(c)}, 32'h0, 1'b0, 0, 1, 0, 0,
          (c inside {2, 3, 12, 13, 15}) ? 4'h0 : 4'(c));
    end
    final_report();
  end
endmodule : tb_top
